// ### tb/spc_host_model.sv
`timescale 1ns/1ns
module spc_host_model
   import spc_pkg::*;
(
   input wire logic clk,
   output logic     serial_data,
   output logic     shift_pulse,
   output logic     frame_select_n
);
   // ==========================================================
   // Controller driving the three pins
   // ==========================================================
   int stretch;
   initial
   begin
      serial_data    = 1'b0;
      shift_pulse    = 1'b0;
      frame_select_n = 1'b1;
      stretch        = 0;
   end
   // Port is static, so a stretched strobe must work as well as 80 ns
   task automatic half();
      repeat (4 + stretch) @(negedge clk);
   endtask
   // A count below sixteen models an aborted frame
   task automatic send(input logic [WORD_W-1:0] w, input int nbits);
      frame_select_n = 1'b0;
      shift_pulse    = 1'b0;
      for (int i = WORD_W - 1; i >= WORD_W - nbits; i--)
      begin
         serial_data = w[i];
         half();
         shift_pulse = 1'b1;
         half();
         shift_pulse = 1'b0;
      end
      serial_data    = ~serial_data;
      frame_select_n = 1'b1;
      repeat (TRAIL_PULSES)
      begin
         half();
         shift_pulse = 1'b1;
         half();
         shift_pulse = 1'b0;
      end
   endtask
endmodule

// ### tb/spc_serial_ctrl_checker.sv
`timescale 1ns/1ns
module spc_serial_ctrl_checker
   import spc_pkg::*;
#(
   parameter int SAMPLE_CYC = 200
) (
   input wire logic               clk,
   input wire logic               rst_b,
   input wire logic               preamp_en,
   input wire logic               tx_suppress_off,
   input wire logic [1:0]         graded_beta,
   input wire logic [1:0]         acoustic_coef_control,
   input wire logic               coef_clear,
   input wire logic               coef_freeze,
   input wire logic [4:0]         rx_level,
   input wire logic               rx_mute,
   input wire logic [1:0]         tx_pga_gain,
   input wire logic [1:0]         network_pga_gain,
   input wire logic [WORD_W-1:0]  gain_echo_control,
   input wire logic [WORD_W-1:0]  volume_duplex_control,
   input wire logic [WORD_W-1:0]  network_detect_thresholds,
   input wire logic [WORD_W-1:0]  acoustic_detect_thresholds,
   input wire logic               sample_tick
);
   // ==========================================================
   // Sample point spacing counter
   // ==========================================================
   int   cnt_r;
   int   cnt_nxt;
   logic seen_r;
   logic seen_nxt;
   logic [4*WORD_W-1:0] regs;
   assign regs = {acoustic_detect_thresholds, network_detect_thresholds,
                  volume_duplex_control, gain_echo_control};
   always_comb
   begin
      cnt_nxt  = sample_tick ? 0 : cnt_r + 1;
      seen_nxt = seen_r | sample_tick;
   end
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_r  <= 0;
         seen_r <= 1'b0;
      end
      else
      begin
         cnt_r  <= cnt_nxt;
         seen_r <= seen_nxt;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence reg_update;
      $changed(regs);
   endsequence
   upd_on_tick_a: assert property (reg_update |-> sample_tick)
      else $error("register changed away from a sample point");
   tick_period_a: assert property (sample_tick && seen_r |-> cnt_r == SAMPLE_CYC - 1)
      else $error("sample points not evenly spaced");
   one_target_a: assert property (reg_update |-> $onehot0({$changed(gain_echo_control),
      $changed(volume_duplex_control), $changed(network_detect_thresholds),
      $changed(acoustic_detect_thresholds)})) else $error("several registers written at once");
   low_bits_a: assert property (regs[2:0] == 3'h0 && regs[18:16] == 3'h2
      && regs[34:32] == 3'h4 && regs[50:48] == 3'h6) else $error("select bits corrupted");
   reset_vals_a: assert property ($rose(rst_b) |-> !sample_tick && regs ==
      {RST_REG3, RST_REG2, RST_REG1, RST_REG0}) else $error("reset values missing");
   field_map_a: assert property ({preamp_en, tx_suppress_off, graded_beta,
      acoustic_coef_control, rx_level, tx_pga_gain} == gain_echo_control[15:3])
      else $error("register 0 fields misplaced");
   net_gain_a: assert property (network_pga_gain == volume_duplex_control[NWG_MSB:NWG_LSB])
      else $error("network gain misplaced");
   coef_decode_a: assert property ({coef_clear, coef_freeze} ==
      {acoustic_coef_control == COEF_CLEAR, acoustic_coef_control == COEF_FREEZE})
      else $error("coefficient decode wrong");
   mute_decode_a: assert property (rx_mute == (rx_level == RXL_MUTE))
      else $error("mute decode wrong");
endmodule

bind spc_serial_ctrl spc_serial_ctrl_checker #(.SAMPLE_CYC(SAMPLE_CYC)) u_chk (
   .clk(clk), .rst_b(rst_b), .preamp_en(preamp_en), .tx_suppress_off(tx_suppress_off),
   .graded_beta(graded_beta), .acoustic_coef_control(acoustic_coef_control),
   .coef_clear(coef_clear), .coef_freeze(coef_freeze), .rx_level(rx_level),
   .rx_mute(rx_mute), .tx_pga_gain(tx_pga_gain), .network_pga_gain(network_pga_gain),
   .gain_echo_control(gain_echo_control), .volume_duplex_control(volume_duplex_control),
   .network_detect_thresholds(network_detect_thresholds),
   .acoustic_detect_thresholds(acoustic_detect_thresholds), .sample_tick(sample_tick));

// ### tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   import spc_pkg::*;
   localparam int SAMP = 200;
   logic clk, rst_b, serial_data, shift_pulse, frame_select_n, sample_tick;
   logic preamp_en, tx_suppress_off, coef_clear, coef_freeze, rx_mute;
   logic [1:0] graded_beta, acoustic_coef_control, tx_pga_gain, network_pga_gain;
   logic [4:0] rx_level;
   logic [WORD_W-1:0] reg0, reg1, reg2, reg3;
   logic [31:0] r;
   logic [WORD_W-1:0] regs_exp [NUM_REGS];
   logic [63:0] got_regs, last, e;
   logic [63:0] note_q [$];
   logic [17:0] got_dec;
   int num_errors, total_checks, seed;
   assign got_regs = {reg3, reg2, reg1, reg0};
   assign got_dec = {preamp_en, tx_suppress_off, graded_beta, acoustic_coef_control,
                     coef_clear, coef_freeze, rx_level, rx_mute, tx_pga_gain, network_pga_gain};
   spc_serial_ctrl #(.SAMPLE_CYC(SAMP)) DUT (
      .clk(clk), .rst_b(rst_b), .serial_data(serial_data), .shift_pulse(shift_pulse),
      .frame_select_n(frame_select_n), .preamp_en(preamp_en),
      .tx_suppress_off(tx_suppress_off), .graded_beta(graded_beta),
      .acoustic_coef_control(acoustic_coef_control), .coef_clear(coef_clear),
      .coef_freeze(coef_freeze), .rx_level(rx_level), .rx_mute(rx_mute),
      .tx_pga_gain(tx_pga_gain), .network_pga_gain(network_pga_gain),
      .gain_echo_control(reg0), .volume_duplex_control(reg1),
      .network_detect_thresholds(reg2), .acoustic_detect_thresholds(reg3),
      .sample_tick(sample_tick));
   spc_host_model host (.clk(clk), .serial_data(serial_data), .shift_pulse(shift_pulse),
                        .frame_select_n(frame_select_n));
   // ==========================================================
   // Expectations and comparisons
   // ==========================================================
   function automatic logic [17:0] dec(input logic [63:0] x);
      logic [1:0] c;
      c = x[ACC_MSB:ACC_LSB];
      return {x[15:10], c == COEF_CLEAR, c == COEF_FREEZE, x[RXL_MSB:RXL_LSB],
              x[RXL_MSB:RXL_LSB] == RXL_MUTE, x[TXG_MSB:TXG_LSB], x[16+NWG_MSB:16+NWG_LSB]};
   endfunction
   task automatic fail(input string what);
      num_errors++;
      $display("wrong value at %0t: %s", $time, what);
   endtask
   task automatic check_regs(input logic [63:0] got, input logic [63:0] exp);
      total_checks++;
      if (got !== exp) fail($sformatf("registers %h, expected %h", got, exp));
   endtask
   task automatic check_dec(input logic [17:0] got, input logic [17:0] exp);
      total_checks++;
      if (got !== exp) fail($sformatf("decoded fields %h, expected %h", got, exp));
   endtask
   task automatic give_verdict();
      if (note_q.size() != 0) fail("expected register update never seen");
      $display("checks %0d, mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Every register change must match the oldest outstanding write
   always @(negedge clk)
   begin
      if (rst_b !== 1'b1)
         last = got_regs;
      else if (got_regs !== last)
      begin
         last = got_regs;
         if (note_q.size() == 0)
            fail("register update with no write pending");
         else
         begin
            e = note_q.pop_front();
            check_regs(got_regs, e);
            check_dec(got_dec, dec(e));
         end
      end
   end
   task automatic do_reset();
      rst_b = 1'b0;
      repeat (4) @(negedge clk);
      rst_b = 1'b1;
      regs_exp = '{RST_REG0, RST_REG1, RST_REG2, RST_REG3};
      @(negedge clk);
      check_regs(got_regs, {RST_REG3, RST_REG2, RST_REG1, RST_REG0});
      check_dec(got_dec, dec({32'h0, RST_REG1, RST_REG0}));
   endtask
   // Spacing of two sample periods keeps writes slower than the sampling
   task automatic write(input int sel, input logic [12:0] d);
      logic [WORD_W-1:0] w;
      if (d === regs_exp[sel][15:3]) d[12] = ~d[12];
      w = {d, sel[1:0], 1'b0};
      regs_exp[sel] = w;
      note_q.push_back({regs_exp[3], regs_exp[2], regs_exp[1], regs_exp[0]});
      host.send(w, WORD_W);
      repeat (2 * SAMP + 10) @(negedge clk);
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      num_errors++;
      give_verdict();
   end
   initial
   begin
      rst_b = 1'b0;
      seed = 21;
      num_errors = 0;
      total_checks = 0;
      @(negedge clk);
      do_reset();
      for (int c = 0; c < 4; c++)
      begin
         r = $random(seed);
         write(0, {c[1:0], r[6:5], c[1:0], r[4:0] & 5'h1E, c[1:0]});
      end
      r = $random(seed);
      write(0, {r[5:0], RXL_MUTE, r[7:6]});
      host.stretch = 6;
      for (int s = 0; s < NUM_REGS; s++)
      begin
         r = $random(seed);
         write(s, r[12:0]);
      end
      host.stretch = 0;
      r = $random(seed);
      host.send(r[15:0], 10);
      repeat (2 * SAMP + 10) @(negedge clk);
      @(posedge sample_tick);
      @(negedge clk);
      r = $random(seed);
      host.send({r[15:3], 3'h0}, WORD_W);
      do_reset();
      repeat (2 * SAMP + 10) @(negedge clk);
      r = $random(seed);
      write(1, r[12:0]);
      give_verdict();
   end
endmodule

// ### verilog/spc_pkg.sv
package spc_pkg;

   // ==========================================================
   // Serial word layout
   // ==========================================================
   localparam int WORD_W       = 16;
   localparam int SEL_W        = 2;
   localparam int SEL_LSB      = 1;
   localparam int DATA_LSB     = 3;
   localparam int NUM_REGS     = 4;
   localparam int TRAIL_PULSES = 4;
   localparam int CNT_W        = 5;

   localparam logic [CNT_W-1:0] BITS_FULL  = 5'h10;
   localparam logic [CNT_W-1:0] TRAIL_LAST = 5'h04;

   // ==========================================================
   // Register 0 fields
   // ==========================================================
   localparam int PREAMP_BIT   = 15;
   localparam int TSUPP_BIT    = 14;
   localparam int GB_MSB       = 13;
   localparam int GB_LSB       = 12;
   localparam int ACC_MSB      = 11;
   localparam int ACC_LSB      = 10;
   localparam int RXL_MSB      = 9;
   localparam int RXL_LSB      = 5;
   localparam int TXG_MSB      = 4;
   localparam int TXG_LSB      = 3;
   // Register 1 network gain field
   localparam int NWG_MSB      = 4;
   localparam int NWG_LSB      = 3;

   localparam logic [1:0] COEF_NORMAL = 2'h0;
   localparam logic [1:0] COEF_CLEAR  = 2'h1;
   localparam logic [1:0] COEF_FREEZE = 2'h2;
   localparam logic [4:0] RXL_MUTE    = 5'h1F;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic [WORD_W-1:0] RST_REG0 = 16'hA080;
   localparam logic [WORD_W-1:0] RST_REG1 = 16'h2142;
   localparam logic [WORD_W-1:0] RST_REG2 = 16'h0004;
   localparam logic [WORD_W-1:0] RST_REG3 = 16'h0006;

   // ==========================================================
   // Timing
   // ==========================================================
   localparam int CLK_FREQ_MHZ     = 100;
   localparam int SAMPLE_PERIOD_US = 125;
   localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_US * CLK_FREQ_MHZ;
   localparam int TICK_W           = 14;

   typedef enum logic [2:0] {
      SPC_IDLE  = 3'b001,
      SPC_SHIFT = 3'b010,
      SPC_TRAIL = 3'b100
   } spc_state_t;

endpackage

// ### verilog/spc_serial_ctrl.sv
// Function
// - Word is 16 bits, shifted most significant bit first.
// - Data captured on each of the first 16 shift pulse rising edges while frame select low.
// - Four pulses with frame select high transfer the word.
// - Shift pulse may be arbitrarily slow; port is static.
// - Latched word sampled every 125 us; writes no faster than that.
// - Port is write-only; no read-back path.
// - Bits b2:b1 select register; bits 15:3 written into it.
// - Register 0 resets to documented field values.
// - Bit 14 of register 0: 1 disables transmit suppression.
// - Transmit gain stage offers four settings, default 0 dB.
// - Network gain stage offers same four settings, default 0 dB.
// - Cold and warm reset both driven from active-low reset input.
// - Preamp enable bit: 0 disables, 1 enables, default enabled.
// - Coefficient control: 00 normal, 01 clear, 10 freeze, 11 reserved.
// - Receive level: 3 dB steps from +30 dB; 11111 mutes.
// - Transmit gain codes 00..11 give 0, 6, 9.5, 12 dB.
`timescale 1ns/1ns
module spc_serial_ctrl
   import spc_pkg::*;
#(
   parameter int                          SAMPLE_CYC = spc_pkg::SAMPLE_CYCLES,
   parameter logic [spc_pkg::WORD_W-1:0]  REG2_RESET = spc_pkg::RST_REG2,
   parameter logic [spc_pkg::WORD_W-1:0]  REG3_RESET = spc_pkg::RST_REG3
) (
   input  wire logic                        clk,
   input  wire logic                        rst_b,
   input  wire logic                        serial_data,
   input  wire logic                        shift_pulse,
   input  wire logic                        frame_select_n,
   output logic                             preamp_en,
   output logic                             tx_suppress_off,
   output logic [1:0]                       graded_beta,
   output logic [1:0]                       acoustic_coef_control,
   output logic                             coef_clear,
   output logic                             coef_freeze,
   output logic [4:0]                       rx_level,
   output logic                             rx_mute,
   output logic [1:0]                       tx_pga_gain,
   output logic [1:0]                       network_pga_gain,
   output logic [spc_pkg::WORD_W-1:0]       gain_echo_control,
   output logic [spc_pkg::WORD_W-1:0]       volume_duplex_control,
   output logic [spc_pkg::WORD_W-1:0]       network_detect_thresholds,
   output logic [spc_pkg::WORD_W-1:0]       acoustic_detect_thresholds,
   output logic                             sample_tick
);
   import spc_pkg::*;

   if (SAMPLE_CYC < 2 || SAMPLE_CYC >= (1 << TICK_W))
   begin : g_bad_period
      $error("SAMPLE_CYC out of range for the sample counter");
   end

   // ==========================================================
   // Pin synchronisers and edge detection
   // ==========================================================
   logic [2:0] pins_s;
   logic       data_s;
   logic       strobe_s;
   logic       frame_n_s;
   logic       strobe_d_r;
   logic       frame_n_d_r;
   logic       strobe_rise;
   logic       frame_fall;

   // Idle levels: data low, strobe low, frame select high
   spc_sync #(
      .WIDTH   (3),
      .RST_VAL (3'h1)
   ) u_sync (
      .clk   (clk),
      .rst_b (rst_b),
      .d     ({serial_data, shift_pulse, frame_select_n}),
      .q     (pins_s)
   );

   assign data_s      = pins_s[2];
   assign strobe_s    = pins_s[1];
   assign frame_n_s   = pins_s[0];
   // Edge found purely from sampled levels, so any slow strobe works
   assign strobe_rise = strobe_s & ~strobe_d_r;
   assign frame_fall  = ~frame_n_s & frame_n_d_r;

   // Frame select resets high so an idle port is not mistaken for a frame
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         strobe_d_r  <= 1'b0;
         frame_n_d_r <= 1'b1;
      end
      else
      begin
         strobe_d_r  <= strobe_s;
         frame_n_d_r <= frame_n_s;
      end
   end

   // ==========================================================
   // Shift register and framing
   // ==========================================================
   spc_state_t        state_r;
   spc_state_t        state_nxt;
   logic [WORD_W-1:0] shift_r;
   logic [WORD_W-1:0] shift_nxt;
   logic [CNT_W-1:0]  bits_r;
   logic [CNT_W-1:0]  bits_nxt;
   logic [CNT_W-1:0]  trail_r;
   logic [CNT_W-1:0]  trail_nxt;
   logic [WORD_W-1:0] pend_r;
   logic [WORD_W-1:0] pend_nxt;
   logic              pend_vld_r;
   logic              pend_vld_nxt;
   logic [TICK_W-1:0] tick_cnt_r;
   logic [TICK_W-1:0] tick_cnt_nxt;
   logic              tick;

   assign tick = (tick_cnt_r == TICK_W'(SAMPLE_CYC - 1));

   always_comb
   begin
      state_nxt    = state_r;
      shift_nxt    = shift_r;
      bits_nxt     = bits_r;
      trail_nxt    = trail_r;
      pend_nxt     = pend_r;
      pend_vld_nxt = pend_vld_r;
      tick_cnt_nxt = tick ? '0 : tick_cnt_r + 1'b1;
      if (tick)
      begin
         pend_vld_nxt = 1'b0;
      end
      case (state_r)
         SPC_IDLE:
         begin
            if (frame_fall)
            begin
               bits_nxt  = '0;
               state_nxt = SPC_SHIFT;
            end
         end
         SPC_SHIFT:
         begin
            if (frame_n_s)
            begin
               // A short frame is dropped; only a full word may go on
               trail_nxt = '0;
               state_nxt = (bits_r == BITS_FULL) ? SPC_TRAIL : SPC_IDLE;
            end
            else if (strobe_rise && bits_r != BITS_FULL)
            begin
               shift_nxt = {shift_r[WORD_W-2:0], data_s};
               bits_nxt  = bits_r + 1'b1;
            end
         end
         SPC_TRAIL:
         begin
            if (!frame_n_s)
            begin
               // New frame before the latch pulses: the old word is lost
               bits_nxt  = '0;
               state_nxt = SPC_SHIFT;
            end
            else if (strobe_rise)
            begin
               trail_nxt = trail_r + 1'b1;
               if (trail_r + 1'b1 == TRAIL_LAST)
               begin
                  pend_nxt     = shift_r;
                  pend_vld_nxt = 1'b1;
                  state_nxt    = SPC_IDLE;
               end
            end
         end
         default:
         begin
            state_nxt = SPC_IDLE;
         end
      endcase
   end

   // Every reset kind lands here alike; partial words vanish
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_r    <= SPC_IDLE;
         shift_r    <= '0;
         bits_r     <= '0;
         trail_r    <= '0;
         pend_r     <= '0;
         pend_vld_r <= 1'b0;
         tick_cnt_r <= '0;
      end
      else
      begin
         state_r    <= state_nxt;
         shift_r    <= shift_nxt;
         bits_r     <= bits_nxt;
         trail_r    <= trail_nxt;
         pend_r     <= pend_nxt;
         pend_vld_r <= pend_vld_nxt;
         tick_cnt_r <= tick_cnt_nxt;
      end
   end

   // ==========================================================
   // Control registers, written only at the sample point
   // ==========================================================
   logic [WORD_W-1:0] regs_r   [NUM_REGS];
   logic [WORD_W-1:0] regs_nxt [NUM_REGS];
   logic [SEL_W-1:0]  sel;
   logic              tick_r;

   assign sel = pend_r[SEL_LSB +: SEL_W];

   // Low bits keep the select code, so each word echoes its own address
   always_comb
   begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
         regs_nxt[i] = regs_r[i];
      end
      if (tick && pend_vld_r)
      begin
         regs_nxt[sel][WORD_W-1:DATA_LSB] = pend_r[WORD_W-1:DATA_LSB];
      end
   end

   // Nothing here feeds back to the pins: the port is write-only
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         regs_r[0] <= RST_REG0;
         regs_r[1] <= RST_REG1;
         regs_r[2] <= REG2_RESET;
         regs_r[3] <= REG3_RESET;
         tick_r    <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < NUM_REGS; i++)
         begin
            regs_r[i] <= regs_nxt[i];
         end
         tick_r <= tick;
      end
   end

   // ==========================================================
   // Decoded controls, registered so outputs come from flops
   // ==========================================================
   logic coef_clear_r;
   logic coef_clear_nxt;
   logic coef_freeze_r;
   logic coef_freeze_nxt;
   logic rx_mute_r;
   logic rx_mute_nxt;

   // Reserved coefficient code 11 behaves as normal adaptation
   always_comb
   begin
      coef_clear_nxt  = (regs_nxt[0][ACC_MSB:ACC_LSB] == COEF_CLEAR);
      coef_freeze_nxt = (regs_nxt[0][ACC_MSB:ACC_LSB] == COEF_FREEZE);
      rx_mute_nxt     = (regs_nxt[0][RXL_MSB:RXL_LSB] == RXL_MUTE);
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         coef_clear_r  <= (RST_REG0[ACC_MSB:ACC_LSB] == COEF_CLEAR);
         coef_freeze_r <= (RST_REG0[ACC_MSB:ACC_LSB] == COEF_FREEZE);
         rx_mute_r     <= (RST_REG0[RXL_MSB:RXL_LSB] == RXL_MUTE);
      end
      else
      begin
         coef_clear_r  <= coef_clear_nxt;
         coef_freeze_r <= coef_freeze_nxt;
         rx_mute_r     <= rx_mute_nxt;
      end
   end

   assign preamp_en             = regs_r[0][PREAMP_BIT];
   assign tx_suppress_off       = regs_r[0][TSUPP_BIT];
   assign graded_beta           = regs_r[0][GB_MSB:GB_LSB];
   assign acoustic_coef_control = regs_r[0][ACC_MSB:ACC_LSB];
   assign coef_clear            = coef_clear_r;
   assign coef_freeze           = coef_freeze_r;
   assign rx_level              = regs_r[0][RXL_MSB:RXL_LSB];
   assign rx_mute               = rx_mute_r;
   assign tx_pga_gain           = regs_r[0][TXG_MSB:TXG_LSB];
   assign network_pga_gain      = regs_r[1][NWG_MSB:NWG_LSB];
   assign gain_echo_control          = regs_r[0];
   assign volume_duplex_control      = regs_r[1];
   assign network_detect_thresholds  = regs_r[2];
   assign acoustic_detect_thresholds = regs_r[3];
   assign sample_tick                = tick_r;

endmodule

// ### verilog/spc_sync.sv
`timescale 1ns/1ns
module spc_sync #(
   parameter int               WIDTH   = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta_r;

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         // Reset to the pins' idle levels so no false edge follows reset
         meta_r <= RST_VAL;
         q      <= RST_VAL;
      end
      else
      begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule
